// *** p5gw_top.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - output pins read back the stored latch value, not the pin level
// - input pins read back the sampled pin level
// - direction bit 1 makes the pin an output, 0 an input
// - direction and latch drive a pin only when mode and segment select allow it
// - direction register is write only and always reads as all ones
// - pull-up follows its control bit while direction bit is 0, stays off while direction bit is 1
// - all pull-ups are off after reset
// - mode bit 0 gives general I/O, 1 gives wakeup request input, all pins
// - mode bit 1 forces wakeup input whatever the direction bit says
// - port offers a wakeup request input function beside general I/O
module p5gw_top
    import p5gw_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    // ahb-lite slave
    input  wire logic                   hsel_in,
    input  wire logic [P5GW_ADDR_W-1:0] haddr_in,
    input  wire logic [1:0]             htrans_in,
    input  wire logic                   hwrite_in,
    input  wire logic [2:0]             hsize_in,
    input  wire logic [P5GW_DATA_W-1:0] hwdata_in,
    input  wire logic                   hready_in,
    output logic      [P5GW_DATA_W-1:0] hrdata_out,
    output logic                        hreadyout_out,
    output logic                        hresp_out,
    // display controller: 1 where its segment select leaves the pin to the port
    input  wire logic [P5GW_PINS-1:0]   segment_select_gio_in,
    // pins
    input  wire logic [P5GW_PINS-1:0]   general_io_pin_in,
    output logic      [P5GW_PINS-1:0]   general_io_pin_out,
    output logic      [P5GW_PINS-1:0]   general_io_pin_oe_out,
    output logic      [P5GW_PINS-1:0]   pullup_en_out,
    // wakeup request to the wakeup controller
    output logic      [P5GW_PINS-1:0]   wakeup_request_input_out,
    output logic                        irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [P5GW_PINS-1:0]   pin_level;

    logic                   pend_r;
    logic                   pend_nxt;
    logic                   pend_write_r;
    logic                   pend_write_nxt;
    p5gw_sel_t              pend_sel_r;
    p5gw_sel_t              pend_sel_nxt;
    logic                   hready_r;
    logic                   hready_nxt;
    logic [P5GW_DATA_W-1:0] hrdata_r;
    logic [P5GW_DATA_W-1:0] hrdata_nxt;

    logic [P5GW_PINS-1:0]   port_data_latch_r;
    logic [P5GW_PINS-1:0]   port_data_latch_nxt;
    logic [P5GW_PINS-1:0]   port_direction_control_r;
    logic [P5GW_PINS-1:0]   port_direction_control_nxt;
    logic [P5GW_PINS-1:0]   port_pullup_control_r;
    logic [P5GW_PINS-1:0]   port_pullup_control_nxt;
    logic [P5GW_PINS-1:0]   port_pin_mode_select_r;
    logic [P5GW_PINS-1:0]   port_pin_mode_select_nxt;
    logic [P5GW_PINS-1:0]   wake_status_r;
    logic [P5GW_PINS-1:0]   wake_status_nxt;
    logic [P5GW_PINS-1:0]   wake_mask_r;
    logic [P5GW_PINS-1:0]   wake_mask_nxt;

    logic [P5GW_PINS-1:0]   pin_out_r;
    logic [P5GW_PINS-1:0]   pin_out_nxt;
    logic [P5GW_PINS-1:0]   pin_oe_r;
    logic [P5GW_PINS-1:0]   pin_oe_nxt;
    logic [P5GW_PINS-1:0]   pullup_r;
    logic [P5GW_PINS-1:0]   pullup_nxt;
    logic [P5GW_PINS-1:0]   wake_req_r;
    logic [P5GW_PINS-1:0]   wake_req_nxt;
    logic [P5GW_PINS-1:0]   wake_prev_r;
    logic [P5GW_PINS-1:0]   wake_prev_nxt;
    logic [P5GW_PINS-1:0]   wake_event;
    logic                   irq_r;
    logic                   irq_nxt;

    logic                   wr_en;
    logic [P5GW_PINS-1:0]   wr_byte;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // address decode, used for every accepted address phase
    function automatic p5gw_sel_t p5gw_decode(input logic [P5GW_ADDR_W-1:0] addr);
        p5gw_sel_t sel;
        sel = P5GW_SEL_NONE;
        unique case (addr[P5GW_OFS_W-1:0])
            P5GW_OFS_DATA:   sel = P5GW_SEL_DATA;
            P5GW_OFS_DIR:    sel = P5GW_SEL_DIR;
            P5GW_OFS_PULLUP: sel = P5GW_SEL_PULLUP;
            P5GW_OFS_MODE:   sel = P5GW_SEL_MODE;
            P5GW_OFS_STATUS: sel = P5GW_SEL_STATUS;
            P5GW_OFS_MASK:   sel = P5GW_SEL_MASK;
            default:         sel = P5GW_SEL_NONE;
        endcase
        if (addr[P5GW_ADDR_W-1:P5GW_OFS_W] != '0)
        begin
            sel = P5GW_SEL_NONE;
        end
        return sel;
    endfunction

    // pins currently owned by the port as general I/O
    function automatic logic [P5GW_PINS-1:0] p5gw_gio(input logic [P5GW_PINS-1:0] mode,
                                                     input logic [P5GW_PINS-1:0] seg);
        return ~mode & seg;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchroniser

    p5gw_sync u_sync
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .raw_in    (general_io_pin_in),
        .level_out (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: address phase, one wait cycle, then the answer

    assign wr_en   = pend_r && !hready_r && pend_write_r;
    assign wr_byte = hwdata_in[P5GW_PINS-1:0];

    // bus next state
    always_comb
    begin
        pend_nxt       = 1'b0;
        pend_write_nxt = pend_write_r;
        pend_sel_nxt   = pend_sel_r;
        hready_nxt     = 1'b1;
        hrdata_nxt     = hrdata_r;
        if (pend_r && !hready_r)
        begin
            // data phase second cycle: answer, reads see registers after any write
            hready_nxt = 1'b1;
            hrdata_nxt = P5GW_RD_ZERO;
            if (!pend_write_r)
            begin
                unique case (pend_sel_r)
                    P5GW_SEL_DATA:
                    begin
                        hrdata_nxt[P5GW_PINS-1:0] =
                            (port_direction_control_r & port_data_latch_r) |
                            (~port_direction_control_r & pin_level);
                    end
                    P5GW_SEL_DIR:    hrdata_nxt[P5GW_PINS-1:0] = P5GW_DIR_READ;
                    P5GW_SEL_PULLUP: hrdata_nxt[P5GW_PINS-1:0] = port_pullup_control_r;
                    P5GW_SEL_MODE:   hrdata_nxt[P5GW_PINS-1:0] = port_pin_mode_select_r;
                    P5GW_SEL_STATUS: hrdata_nxt[P5GW_PINS-1:0] = wake_status_r;
                    P5GW_SEL_MASK:   hrdata_nxt[P5GW_PINS-1:0] = wake_mask_r;
                    P5GW_SEL_NONE:   hrdata_nxt = P5GW_RD_ZERO;
                    default:         hrdata_nxt = P5GW_RD_ZERO;
                endcase
            end
        end
        else if (hsel_in && hready_in && (htrans_in == P5GW_HTRANS_NONSEQ))
        begin
            // address phase taken; hsize is always a word here
            pend_nxt       = 1'b1;
            pend_write_nxt = hwrite_in;
            pend_sel_nxt   = p5gw_decode(haddr_in);
            hready_nxt     = 1'b0;
        end
    end

    // bus registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pend_r       <= 1'b0;
            pend_write_r <= 1'b0;
            pend_sel_r   <= P5GW_SEL_NONE;
            hready_r     <= 1'b1;
            hrdata_r     <= P5GW_RD_ZERO;
        end
        else
        begin
            pend_r       <= pend_nxt;
            pend_write_r <= pend_write_nxt;
            pend_sel_r   <= pend_sel_nxt;
            hready_r     <= hready_nxt;
            hrdata_r     <= hrdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port registers

    // register file next values
    always_comb
    begin
        port_data_latch_nxt        = port_data_latch_r;
        port_direction_control_nxt = port_direction_control_r;
        port_pullup_control_nxt    = port_pullup_control_r;
        port_pin_mode_select_nxt   = port_pin_mode_select_r;
        wake_mask_nxt              = wake_mask_r;
        wake_status_nxt            = wake_status_r;
        if (wr_en)
        begin
            unique case (pend_sel_r)
                P5GW_SEL_DATA:   port_data_latch_nxt        = wr_byte;
                P5GW_SEL_DIR:    port_direction_control_nxt = wr_byte;
                P5GW_SEL_PULLUP: port_pullup_control_nxt    = wr_byte;
                P5GW_SEL_MODE:   port_pin_mode_select_nxt   = wr_byte;
                P5GW_SEL_STATUS: wake_status_nxt            = wake_status_r & ~wr_byte;
                P5GW_SEL_MASK:   wake_mask_nxt              = wr_byte;
                P5GW_SEL_NONE:   wake_mask_nxt              = wake_mask_r;
                default:         wake_mask_nxt              = wake_mask_r;
            endcase
        end
        // a new event wins over a clear in the same cycle
        wake_status_nxt = wake_status_nxt | wake_event;
    end

    // register file flops
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            port_data_latch_r        <= P5GW_RST_BYTE;
            port_direction_control_r <= P5GW_RST_BYTE;
            port_pullup_control_r    <= P5GW_RST_BYTE;
            port_pin_mode_select_r   <= P5GW_RST_BYTE;
            wake_status_r            <= P5GW_RST_BYTE;
            wake_mask_r              <= P5GW_RST_BYTE;
        end
        else
        begin
            port_data_latch_r        <= port_data_latch_nxt;
            port_direction_control_r <= port_direction_control_nxt;
            port_pullup_control_r    <= port_pullup_control_nxt;
            port_pin_mode_select_r   <= port_pin_mode_select_nxt;
            wake_status_r            <= wake_status_nxt;
            wake_mask_r              <= wake_mask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin control and wakeup

    // falling edge on a wakeup-mode pin is a wakeup event
    assign wake_event = wake_prev_r & ~wake_req_nxt & port_pin_mode_select_r;

    // pin drive, pull-up and wakeup routing
    always_comb
    begin
        // output only for general I/O with direction 1; mode 1 forces input
        pin_oe_nxt   = p5gw_gio(port_pin_mode_select_r, segment_select_gio_in)
                     & port_direction_control_r;
        pin_out_nxt  = port_data_latch_r & pin_oe_nxt;
        pullup_nxt   = port_pullup_control_r & ~port_direction_control_r;
        // wakeup-mode pins pass their level, others idle high
        wake_req_nxt = (pin_level & port_pin_mode_select_r)
                     | ~port_pin_mode_select_r;
        wake_prev_nxt = wake_req_nxt;
        irq_nxt      = |(wake_status_nxt & wake_mask_r);
    end

    // pin and interrupt flops
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_out_r   <= P5GW_RST_BYTE;
            pin_oe_r    <= P5GW_RST_BYTE;
            pullup_r    <= P5GW_RST_BYTE;
            wake_req_r  <= ~P5GW_RST_BYTE;
            wake_prev_r <= ~P5GW_RST_BYTE;
            irq_r       <= 1'b0;
        end
        else
        begin
            pin_out_r   <= pin_out_nxt;
            pin_oe_r    <= pin_oe_nxt;
            pullup_r    <= pullup_nxt;
            wake_req_r  <= wake_req_nxt;
            wake_prev_r <= wake_prev_nxt;
            irq_r       <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops except the constant hresp_out

    assign hrdata_out               = hrdata_r;
    assign hreadyout_out            = hready_r;
    assign hresp_out                = P5GW_HRESP_OKAY;
    assign general_io_pin_out       = pin_out_r;
    assign general_io_pin_oe_out    = pin_oe_r;
    assign pullup_en_out            = pullup_r;
    assign wakeup_request_input_out = wake_req_r;
    assign irq_out                  = irq_r;

endmodule // p5gw_top

// *** p5gw_pkg.sv ***
package p5gw_pkg;

    // port geometry
    localparam int unsigned P5GW_PINS   = 8;
    localparam int unsigned P5GW_DATA_W = 32;
    localparam int unsigned P5GW_ADDR_W = 32;
    localparam int unsigned P5GW_OFS_W  = 5;

    // register byte offsets
    localparam logic [4:0] P5GW_OFS_DATA   = 5'h00;
    localparam logic [4:0] P5GW_OFS_DIR    = 5'h04;
    localparam logic [4:0] P5GW_OFS_PULLUP = 5'h08;
    localparam logic [4:0] P5GW_OFS_MODE   = 5'h0C;
    localparam logic [4:0] P5GW_OFS_STATUS = 5'h10;
    localparam logic [4:0] P5GW_OFS_MASK   = 5'h14;

    // reset values and read patterns
    localparam logic [7:0]  P5GW_RST_BYTE  = 8'h00;
    localparam logic [7:0]  P5GW_DIR_READ  = 8'hFF;
    localparam logic [31:0] P5GW_RD_ZERO   = 32'h0000_0000;

    // ahb-lite codes
    localparam logic [1:0] P5GW_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] P5GW_HSIZE_WORD    = 3'h2;
    localparam logic       P5GW_HRESP_OKAY    = 1'h0;

    // register selector
    typedef enum logic [2:0]
    {
        P5GW_SEL_DATA,
        P5GW_SEL_DIR,
        P5GW_SEL_PULLUP,
        P5GW_SEL_MODE,
        P5GW_SEL_STATUS,
        P5GW_SEL_MASK,
        P5GW_SEL_NONE
    } p5gw_sel_t;

endpackage

// *** p5gw_sync.sv ***
`timescale 1ns/1ps

// three-stage pin synchroniser, filtered level updates when stages two and three agree
module p5gw_sync
    import p5gw_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic [P5GW_PINS-1:0] raw_in,
    output logic      [P5GW_PINS-1:0] level_out
);

    logic [P5GW_PINS-1:0] meta_r;
    logic [P5GW_PINS-1:0] stage2_r;
    logic [P5GW_PINS-1:0] stage3_r;
    logic [P5GW_PINS-1:0] level_r;
    logic [P5GW_PINS-1:0] level_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // per-pin agreement filter
    genvar g;
    generate
        for (g = 0; g < P5GW_PINS; g++)
        begin : g_pin
            always_comb
            begin
                level_nxt[g] = (stage2_r[g] == stage3_r[g]) ? stage3_r[g] : level_r[g];
            end
        end
    endgenerate

    // register chain, first stage feeds only the second
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_r   <= P5GW_RST_BYTE;
            stage2_r <= P5GW_RST_BYTE;
            stage3_r <= P5GW_RST_BYTE;
            level_r  <= P5GW_RST_BYTE;
        end
        else
        begin
            meta_r   <= raw_in;
            stage2_r <= meta_r;
            stage3_r <= stage2_r;
            level_r  <= level_nxt;
        end
    end

    assign level_out = level_r;

endmodule // p5gw_sync

// *** p5gw_monitor.sv ***
`timescale 1ns/1ps

// bus, pin and wakeup relations seen at the port top
module p5gw_monitor
    import p5gw_pkg::*;
(
    input wire logic                   clk_in,
    input wire logic                   rst_in,
    input wire logic                   hsel_in,
    input wire logic [P5GW_ADDR_W-1:0] haddr_in,
    input wire logic [1:0]             htrans_in,
    input wire logic                   hwrite_in,
    input wire logic [2:0]             hsize_in,
    input wire logic [P5GW_DATA_W-1:0] hwdata_in,
    input wire logic                   hready_in,
    input wire logic [P5GW_DATA_W-1:0] hrdata_out,
    input wire logic                   hreadyout_out,
    input wire logic                   hresp_out,
    input wire logic [P5GW_PINS-1:0]   segment_select_gio_in,
    input wire logic [P5GW_PINS-1:0]   general_io_pin_in,
    input wire logic [P5GW_PINS-1:0]   general_io_pin_out,
    input wire logic [P5GW_PINS-1:0]   general_io_pin_oe_out,
    input wire logic [P5GW_PINS-1:0]   pullup_en_out,
    input wire logic [P5GW_PINS-1:0]   wakeup_request_input_out,
    input wire logic                   irq_out
);
    // transfer taken while the slave is idle
    wire logic req = hsel_in & hready_in & (htrans_in == P5GW_HTRANS_NONSEQ) & hreadyout_out;
    wire logic [P5GW_PINS-1:0] oe = general_io_pin_oe_out;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    a_out_gated: assert property ((general_io_pin_out & ~oe) == 8'h00)
        else $error("pin value driven outside output enable");
    a_pullup_excl: assert property ((pullup_en_out & oe) == 8'h00)
        else $error("pull-up on while pin is an output");
    a_wake_undriven: assert property
        ((~wakeup_request_input_out & ~$past(wakeup_request_input_out) & oe) == 8'h00)
        else $error("wakeup pin still driven");
    a_pullup_by_write: assert property (!$stable(pullup_en_out) |->
        !$past(hreadyout_out, 1) || !$past(hreadyout_out, 2) || !$past(hreadyout_out, 3))
        else $error("pull-up changed without a register write");
    a_oe_cause: assert property (!$stable(oe) |->
        !$past(hreadyout_out, 1) || !$past(hreadyout_out, 2) || !$past(hreadyout_out, 3)
        || $past(segment_select_gio_in, 1) != $past(segment_select_gio_in, 2)
        || $past(segment_select_gio_in, 2) != $past(segment_select_gio_in, 3))
        else $error("output enable changed without cause");
    a_dir_reads_ones: assert property
        (req && !hwrite_in && haddr_in == {27'h0, P5GW_OFS_DIR}
        |=> !hreadyout_out ##1 hrdata_out == 32'h0000_00FF)
        else $error("direction register read not all ones");
    a_ready_pulse: assert property (req |=> !hreadyout_out ##1 hreadyout_out)
        else $error("ready not low for exactly one cycle");
    a_ready_cause: assert property ($fell(hreadyout_out) |-> $past(req))
        else $error("ready dropped without a transfer");
endmodule // p5gw_monitor

// *** p5gw_pin_model.sv ***
`timescale 1ns/1ps

// board side of the pins: driver, external source, pull-up or a floating line
module p5gw_pin_model
    import p5gw_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic [P5GW_PINS-1:0] oe_in,
    input  wire logic [P5GW_PINS-1:0] drive_in,
    input  wire logic [P5GW_PINS-1:0] pullup_in,
    input  wire logic [P5GW_PINS-1:0] ext_in,
    input  wire logic [P5GW_PINS-1:0] ext_en_in,
    output logic      [P5GW_PINS-1:0] level_out
);
    logic [P5GW_PINS-1:0] float_r = 8'h55;

    // a floating line wanders every cycle
    always_ff @(posedge clk_in)
        float_r <= ~float_r;

    // port driver wins, then the board source, then the pull-up
    always_comb
        level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_in)
                  | (~oe_in & ~ext_en_in & (pullup_in | float_r));
endmodule // p5gw_pin_model

// *** p5gw_tb_top.sv ***
`timescale 1ns/1ps

module p5gw_tb_top
    import p5gw_pkg::*;
;
    localparam logic [31:0] A_DAT = {27'h0, P5GW_OFS_DATA};
    localparam logic [31:0] A_DIR = {27'h0, P5GW_OFS_DIR};
    localparam logic [31:0] A_PU  = {27'h0, P5GW_OFS_PULLUP};
    localparam logic [31:0] A_MOD = {27'h0, P5GW_OFS_MODE};
    localparam logic [31:0] A_ST  = {27'h0, P5GW_OFS_STATUS};
    localparam logic [31:0] A_MSK = {27'h0, P5GW_OFS_MASK};

    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  seg    = 8'hFF;
    logic [7:0]  ext    = 8'h00;
    logic [7:0]  ext_en = 8'hFF;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [7:0]  lvl, pout, poe, pu, wk;
    logic        irq;
    int          errors = 0;
    int          n_compared = 0;

    // clock generator
    initial
        forever #4 clk_in = ~clk_in;

    p5gw_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(P5GW_HSIZE_WORD),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .segment_select_gio_in(seg),
        .general_io_pin_in(lvl), .general_io_pin_out(pout), .general_io_pin_oe_out(poe),
        .pullup_en_out(pu), .wakeup_request_input_out(wk), .irq_out(irq));

    p5gw_pin_model i_pins (.clk_in(clk_in), .oe_in(poe), .drive_in(pout), .pullup_in(pu),
        .ext_in(ext), .ext_en_in(ext_en), .level_out(lvl));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // edge by edge until hready is seen high, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (hready !== 1'b1 && n < 64);
        if (n >= 64)
        begin
            errors++;
            final_report();
        end
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= P5GW_HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 8'h00, r);
        chk(r, {24'h0, e});
    endtask

    task automatic pin_chk(input logic [7:0] oe_e, input logic [7:0] out_e,
                           input logic [7:0] pu_e);
        chk({24'h0, poe}, {24'h0, oe_e});
        chk({24'h0, pout}, {24'h0, out_e});
        chk({24'h0, pu}, {24'h0, pu_e});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reset values, write-only direction, unmapped place
    task automatic t_reset();
        rd_chk(A_DAT, 8'h00);
        rd_chk(A_DIR, 8'hFF);
        rd_chk(A_PU, 8'h00);
        rd_chk(A_MOD, 8'h00);
        pin_chk(8'h00, 8'h00, 8'h00);
        chk({24'h0, wk}, 32'hFF);
        wr(32'h20, 8'hFF);
        rd_chk(32'h20, 8'h00);
        rd_chk(A_DAT, 8'h00);
    endtask

    // low nibble outputs, pins 4-5 pulled up, pins 6-7 from the board
    task automatic t_output();
        ext_en <= 8'hC0;
        ext <= 8'h40;
        wr(A_DIR, 8'h0F);
        wr(A_DAT, 8'hA5);
        wr(A_PU, 8'hFF);
        repeat (8) @(posedge clk_in);
        rd_chk(A_DAT, 8'h75);
        rd_chk(A_DIR, 8'hFF);
        rd_chk(A_PU, 8'hFF);
        pin_chk(8'h0F, 8'h05, 8'hF0);
    endtask

    // display takes the low nibble, then gives it back
    task automatic t_segment();
        seg <= 8'hF0;
        repeat (3) @(posedge clk_in);
        pin_chk(8'h00, 8'h00, 8'hF0);
        rd_chk(A_DAT, 8'h75);
        seg <= 8'hFF;
        repeat (3) @(posedge clk_in);
        pin_chk(8'h0F, 8'h05, 8'hF0);
    endtask

    // pins 0-1 become wakeup inputs, fall, raise and clear the interrupt
    task automatic t_wakeup();
        ext <= 8'h03;
        ext_en <= 8'hFF;
        wr(A_MOD, 8'h03);
        repeat (8) @(posedge clk_in);
        pin_chk(8'h0C, 8'h04, 8'hF0);
        chk({24'h0, wk}, 32'hFF);
        rd_chk(A_MOD, 8'h03);
        ext <= 8'h00;
        repeat (8) @(posedge clk_in);
        chk({24'h0, wk}, 32'hFC);
        rd_chk(A_ST, 8'h03);
        chk({31'h0, irq}, 32'h0);
        wr(A_MSK, 8'h02);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h1);
        wr(A_ST, 8'h02);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        rd_chk(A_ST, 8'h01);
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_output();
        t_segment();
        t_wakeup();
        final_report();
    end
endmodule // p5gw_tb_top

bind p5gw_top p5gw_monitor i_mon (.*);
